// file: hdl/tcc_top.sv
// Contract
// - accepted entry loads the calendar counters
// - report request snapshots displayed time for pattern
// - fitted gps loads calendar on valid fix
// - trim 0 to 15, default 8, higher slower
// - each trim step shifts 0.64 s per day
// - soft reset or power-off stops; power-on restarts
// - hour offset -12 to +12, default 0, display
// - calendar value feeds logging and message stamps
`timescale 1ns/1ps
`include "tcc_regs.svh"
module tcc_top
   import tcc_pkg::*;
#(
   parameter int SEC_CYCLES = `TCC_SEC_CYCLES,
   parameter int TRIM_STEP = `TCC_TRIM_STEP_CYCLES
)
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // system state
   input wire logic soft_reset,
   input wire logic power_ok,
   // gps receiver
   input wire logic gps_fitted,
   input wire logic gps_fix_valid,
   input wire tcc_time_t gps_time,
   // time for logging and stamps
   output tcc_disp_t stamp_time,
   output logic second_pulse,
   output logic running
);
   logic acc; // access edge where the write lands
   logic wr; // write at that edge
   logic rd_done; // read completes at that edge
   logic hit; // address is mapped
   logic [31:0] rd_val; // read data mux
   logic sw_load; // software entry strobe
   logic sw_report; // report snapshot strobe
   logic gps_load; // gps load strobe
   logic load_any; // either load
   tcc_time_t entry_val; // software entry decoded
   tcc_time_t load_val; // value to load
   tcc_time_t now; // live calendar
   tcc_disp_t disp; // calendar with hour offset applied
   tcc_disp_t rep; // snapshot for report
   logic [31:0] set_date; // staged entry date
   logic [31:0] set_time; // staged entry time
   logic [3:0] clock_trim; // tick rate trim
   logic signed [4:0] hour_offset; // display zone offset
   logic [7:0] display_pattern; // display format selector
   logic gps_loaded; // sticky: gps has set the clock
   logic report_ready; // sticky: snapshot waiting
   logic fix_q; // fix level one cycle ago
   logic power_q; // power level one cycle ago
   logic tick; // trimmed one-second enable
   logic signed [6:0] hour_sum; // hour plus offset before wrap

   // packs a date into the register layout
   function automatic logic [31:0] pack_date(input tcc_time_t t);
      pack_date = 32'h0;
      pack_date[`TCC_DATE_YEAR_LSB +: 14] = t.year;
      pack_date[`TCC_DATE_MONTH_LSB +: 4] = t.month;
      pack_date[`TCC_DATE_DAY_LSB +: 5] = t.day;
   endfunction

   // packs a time of day and day shift
   function automatic logic [31:0] pack_time(input tcc_time_t t,
                                             input logic [1:0] sh);
      pack_time = 32'h0;
      pack_time[`TCC_TIME_SEC_LSB +: 6] = t.second;
      pack_time[`TCC_TIME_MIN_LSB +: 6] = t.minute;
      pack_time[`TCC_TIME_HOUR_LSB +: 5] = t.hour;
      pack_time[`TCC_TIME_SHIFT_LSB +: 2] = sh;
   endfunction

   // apb phases: one wait state, answer on the second access cycle
   assign acc = psel && penable && pready;
   assign wr = acc && pwrite;
   assign rd_done = acc && !pwrite;

   // strobes come only from the completing write
   assign sw_load = wr && paddr == `TCC_OFS_CTRL && pwdata[`TCC_CTRL_LOAD];
   assign sw_report = wr && paddr == `TCC_OFS_CTRL &&
                      pwdata[`TCC_CTRL_REPORT];

   // entry fields sit in fixed slots whatever the pattern says
   always_comb
   begin
      entry_val.year = set_date[`TCC_DATE_YEAR_LSB +: 14];
      entry_val.month = set_date[`TCC_DATE_MONTH_LSB +: 4];
      entry_val.day = set_date[`TCC_DATE_DAY_LSB +: 5];
      entry_val.hour = set_time[`TCC_TIME_HOUR_LSB +: 5];
      entry_val.minute = set_time[`TCC_TIME_MIN_LSB +: 6];
      // without the seconds flag the second count starts at zero
      entry_val.second = pwdata[`TCC_CTRL_SECS] ?
                         set_time[`TCC_TIME_SEC_LSB +: 6] : 6'h0;
   end

   // gps fix edge; software entry wins a tie
   assign gps_load = gps_fitted && gps_fix_valid && !fix_q && !sw_load;
   assign load_any = sw_load || gps_load;
   assign load_val = sw_load ? entry_val : gps_time;

   // address decode and read mux; unmapped reads zero with error
   always_comb
   begin
      hit = 1'b1;
      rd_val = 32'h0;
      case (paddr)
         `TCC_OFS_CTRL: rd_val = 32'h0;
         `TCC_OFS_SET_DATE: rd_val = set_date;
         `TCC_OFS_SET_TIME: rd_val = set_time;
         `TCC_OFS_TRIM: rd_val = {28'h0, clock_trim};
         `TCC_OFS_ZONE: rd_val = {{27{hour_offset[4]}}, hour_offset};
         `TCC_OFS_PATTERN: rd_val = {24'h0, display_pattern};
         `TCC_OFS_STATUS:
            rd_val = {28'h0, gps_fitted, report_ready, gps_loaded, running};
         `TCC_OFS_NOW_DATE: rd_val = pack_date(now);
         `TCC_OFS_NOW_TIME: rd_val = pack_time(now, 2'h0);
         `TCC_OFS_REP_DATE: rd_val = pack_date(rep.t);
         `TCC_OFS_REP_TIME: rd_val = pack_time(rep.t, rep.day_shift);
         default: hit = 1'b0;
      endcase
   end

   // apb answer flops
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pready <= 1'b0;
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel && penable && !pready;
         if (psel && penable && !pready)
         begin
            prdata <= pwrite ? 32'h0 : rd_val;
            pslverr <= !hit;
         end
         else if (!psel)
         begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
         end
      end
   end

   // software settings
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         set_date <= 32'h0;
         set_time <= 32'h0;
         clock_trim <= `TCC_RST_TRIM;
         hour_offset <= `TCC_RST_ZONE;
         display_pattern <= `TCC_RST_PATTERN;
      end
      else if (wr)
      begin
         case (paddr)
            `TCC_OFS_SET_DATE: set_date <= pwdata;
            `TCC_OFS_SET_TIME: set_time <= pwdata;
            `TCC_OFS_TRIM: clock_trim <= pwdata[3:0];
            `TCC_OFS_ZONE:
               // out of range offsets are dropped, old value kept
               if ($signed(pwdata[4:0]) >= $signed(`TCC_ZONE_MIN) &&
                   $signed(pwdata[4:0]) <= $signed(`TCC_ZONE_MAX) &&
                   pwdata[31:5] == {27{pwdata[4]}})
                  hour_offset <= pwdata[4:0];
            `TCC_OFS_PATTERN: display_pattern <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // run state: power-on starts, soft reset or power loss stops
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         running <= 1'b1;
         power_q <= 1'b1;
      end
      else
      begin
         power_q <= power_ok;
         if (soft_reset || !power_ok)
            running <= 1'b0;
         else if (power_ok && !power_q)
            running <= 1'b1;
      end
   end

   // sticky status; a new event beats a clear in the same cycle
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fix_q <= 1'b0;
         gps_loaded <= 1'b0;
         report_ready <= 1'b0;
      end
      else
      begin
         fix_q <= gps_fix_valid;
         if (gps_load)
            gps_loaded <= 1'b1;
         else if (wr && paddr == `TCC_OFS_STATUS && pwdata[`TCC_ST_GPSLD])
            gps_loaded <= 1'b0;
         if (sw_report)
            report_ready <= 1'b1;
         else if (rd_done && paddr == `TCC_OFS_REP_TIME)
            report_ready <= 1'b0;
      end
   end

   // trimmed second divider, rephased on every load
   tcc_tick #(
      .SEC_CYCLES(SEC_CYCLES),
      .TRIM_STEP(TRIM_STEP)
   ) u_tick (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .run(running && !soft_reset && power_ok),
      .restart(load_any),
      .trim(clock_trim),
      .tick(tick)
   );

   // calendar counters
   tcc_cal u_cal (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .tick(tick),
      .load(load_any),
      .load_val(load_val),
      .now(now)
   );

   // zone offset on the hour; date shift is flagged, not applied
   always_comb
   begin
      hour_sum = $signed({2'b00, now.hour}) + 7'(hour_offset);
      disp.t = now;
      disp.day_shift = 2'h0;
      if (hour_sum < 0)
      begin
         disp.t.hour = 5'(hour_sum + 7'(`TCC_HOURS_DAY));
         disp.day_shift = 2'h3;
      end
      else if (hour_sum >= 7'(`TCC_HOURS_DAY))
      begin
         disp.t.hour = 5'(hour_sum - 7'(`TCC_HOURS_DAY));
         disp.day_shift = 2'h1;
      end
      else
         disp.t.hour = 5'(hour_sum);
   end

   // report snapshot and stamp outputs
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rep <= '0;
         stamp_time <= '0;
         second_pulse <= 1'b0;
      end
      else
      begin
         if (sw_report)
            rep <= disp;
         stamp_time <= disp;
         second_pulse <= tick;
      end
   end

   chk_entry_load: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      sw_load |=> now == $past(entry_val))
      else $error("entry not loaded into calendar");
   chk_entry_order: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      sw_load |=> now.year == $past(set_date[13:0]) &&
                  now.minute == $past(set_time[13:8]))
      else $error("entry fields taken from wrong slots");
   chk_report_snap: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      sw_report |=> rep == $past(disp) ##1 report_ready)
      else $error("report snapshot wrong");
   chk_gps_load: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (gps_fitted && $rose(gps_fix_valid) && !sw_load)
      |=> now == $past(gps_time) && gps_loaded)
      else $error("gps time not loaded on fix");
   chk_trim_write: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (wr && paddr == `TCC_OFS_TRIM) |=> clock_trim == $past(pwdata[3:0]))
      else $error("trim write lost");
   chk_stop_count: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (soft_reset && !load_any) |=> !running && $stable(now))
      else $error("calendar ran after stop");
   chk_zone_range: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      hour_offset >= -5'sd12 && hour_offset <= 5'sd12 &&
      disp.t.hour < 5'h18)
      else $error("offset or displayed hour out of range");
   chk_stamp_follow: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      rst_n |=> stamp_time == $past(disp) && second_pulse == $past(tick))
      else $error("stamp not following calendar");
   chk_sec_zero: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (sw_load && !pwdata[`TCC_CTRL_SECS]) |=> now.second == 6'h0)
      else $error("omitted seconds not zero");
endmodule

// file: common/tcc_regs.svh
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH
// register byte offsets on the apb port
`define TCC_OFS_CTRL 8'h00
`define TCC_OFS_SET_DATE 8'h04
`define TCC_OFS_SET_TIME 8'h08
`define TCC_OFS_TRIM 8'h0c
`define TCC_OFS_ZONE 8'h10
`define TCC_OFS_PATTERN 8'h14
`define TCC_OFS_STATUS 8'h18
`define TCC_OFS_NOW_DATE 8'h1c
`define TCC_OFS_NOW_TIME 8'h20
`define TCC_OFS_REP_DATE 8'h24
`define TCC_OFS_REP_TIME 8'h28
// control strobe bits
`define TCC_CTRL_LOAD 0
`define TCC_CTRL_REPORT 1
`define TCC_CTRL_SECS 2
// status bits
`define TCC_ST_RUN 0
`define TCC_ST_GPSLD 1
`define TCC_ST_REPRDY 2
`define TCC_ST_GPSFIT 3
// packed date word fields
`define TCC_DATE_YEAR_LSB 0
`define TCC_DATE_MONTH_LSB 16
`define TCC_DATE_DAY_LSB 24
// packed time word fields
`define TCC_TIME_SEC_LSB 0
`define TCC_TIME_MIN_LSB 8
`define TCC_TIME_HOUR_LSB 16
`define TCC_TIME_SHIFT_LSB 30
// reset values
`define TCC_RST_YEAR 14'h07d0
`define TCC_RST_MONTH 4'h1
`define TCC_RST_DAY 5'h01
`define TCC_RST_TRIM 4'h8
`define TCC_RST_ZONE 5'h00
`define TCC_RST_PATTERN 8'h00
// trim mid point and zone limits
`define TCC_TRIM_MID 8
`define TCC_ZONE_MIN 5'h14
`define TCC_ZONE_MAX 5'h0c
`define TCC_HOURS_DAY 6'h18
// timing
`define TCC_CLK_HZ 125000000
`define TCC_DRIFT_MS 640
`define TCC_DAY_S 86400
`define TCC_SEC_CYCLES (`TCC_CLK_HZ)
`define TCC_TRIM_STEP_CYCLES \
   ((`TCC_CLK_HZ / 1000) * `TCC_DRIFT_MS / `TCC_DAY_S)
`endif

// file: common/tcc_pkg.sv
package tcc_pkg;
   // one calendar value, binary fields
   typedef struct packed {
      logic [13:0] year;
      logic [3:0] month;
      logic [4:0] day;
      logic [4:0] hour;
      logic [5:0] minute;
      logic [5:0] second;
   } tcc_time_t;
   // displayed value: 01 next day, 11 previous day, 00 same day
   typedef struct packed {
      logic [1:0] day_shift;
      tcc_time_t t;
   } tcc_disp_t;
endpackage

// file: hdl/tcc_tick.sv
`timescale 1ns/1ps
`include "tcc_regs.svh"
module tcc_tick
   import tcc_pkg::*;
#(
   parameter int SEC_CYCLES = `TCC_SEC_CYCLES,
   parameter int TRIM_STEP = `TCC_TRIM_STEP_CYCLES
)
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // control
   input wire logic run,
   input wire logic restart,
   input wire logic [3:0] trim,
   // one-second enable
   output logic tick
);
   int signed period_i; // signed so a low trim cannot wrap
   logic [31:0] period; // cycles per trimmed second
   logic [31:0] count; // cycles into the current second
   logic [31:0] gap; // checking only: cycles since last tick
   logic gap_ok; // checking only: gap is a clean interval
   logic [3:0] trim_q; // checking only: trim one cycle ago

   // larger trim means more cycles per second, so a slower clock
   always_comb
   begin
      period_i = SEC_CYCLES + (int'(trim) - `TCC_TRIM_MID) * TRIM_STEP;
      if (period_i < 1)
      begin
         period_i = 1;
      end
      period = 32'(period_i);
   end

   // second divider; holds its phase while stopped
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         count <= 32'h0;
      else if (restart)
         count <= 32'h0;
      else if (run)
         count <= (count >= period - 32'h1) ? 32'h0 : count + 32'h1;
   end

   assign tick = run && !restart && (count >= period - 32'h1);

   // helper counter for the interval check
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         gap <= 32'h0;
         gap_ok <= 1'b0;
         trim_q <= `TCC_RST_TRIM;
      end
      else
      begin
         trim_q <= trim;
         if (restart || trim != trim_q)
         begin
            gap <= 32'h0;
            gap_ok <= 1'b0;
         end
         else if (tick)
         begin
            gap <= 32'h0;
            gap_ok <= 1'b1;
         end
         else if (run)
            gap <= gap + 32'h1;
      end
   end

   chk_tick_gap: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (tick && gap_ok && trim == trim_q) |-> gap == period - 32'h1)
      else $error("trimmed second length wrong");
endmodule

// file: hdl/tcc_cal.sv
`timescale 1ns/1ps
`include "tcc_regs.svh"
module tcc_cal
   import tcc_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // advance and load
   input wire logic tick,
   input wire logic load,
   input wire tcc_time_t load_val,
   // current value
   output tcc_time_t now
);
   tcc_time_t next_now; // value after one second

   // gregorian month length; 100 and 400 year rules included
   function automatic logic [4:0] month_days(input logic [13:0] y,
                                             input logic [3:0] m);
      logic leap;
      leap = (y[1:0] == 2'h0) &&
             (((y % 14'h0064) != 14'h0) || ((y % 14'h0190) == 14'h0));
      case (m)
         4'h2: month_days = leap ? 5'h1d : 5'h1c;
         4'h4, 4'h6, 4'h9, 4'hb: month_days = 5'h1e;
         default: month_days = 5'h1f;
      endcase
   endfunction

   // carry chain seconds through years
   always_comb
   begin
      next_now = now;
      if (now.second < 6'h3b)
         next_now.second = now.second + 6'h1;
      else
      begin
         next_now.second = 6'h0;
         if (now.minute < 6'h3b)
            next_now.minute = now.minute + 6'h1;
         else
         begin
            next_now.minute = 6'h0;
            if (now.hour < 5'h17)
               next_now.hour = now.hour + 5'h1;
            else
            begin
               next_now.hour = 5'h0;
               if (now.day < month_days(now.year, now.month))
                  next_now.day = now.day + 5'h1;
               else
               begin
                  next_now.day = 5'h1;
                  if (now.month < 4'hc)
                     next_now.month = now.month + 4'h1;
                  else
                  begin
                     next_now.month = 4'h1;
                     next_now.year = now.year + 14'h1;
                  end
               end
            end
         end
      end
   end

   // a load beats a tick in the same cycle
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         now <= '{year: `TCC_RST_YEAR, month: `TCC_RST_MONTH,
                  day: `TCC_RST_DAY, hour: 5'h0, minute: 6'h0,
                  second: 6'h0};
      else if (load)
         now <= load_val;
      else if (tick)
         now <= next_now;
   end
endmodule

// file: test/tcc_gps_model.sv
`timescale 1ns/1ps
module tcc_gps_model
   import tcc_pkg::*;
#(
   parameter int FIX_DELAY = 5
)
(
   // clock
   input wire logic clk_sys,
   // bench control
   input wire logic fitted,
   input wire logic acquire,
   input wire tcc_time_t fix_time,
   // receiver outputs
   output logic gps_fitted,
   output logic gps_fix_valid,
   output tcc_time_t gps_time
);
   int cnt; // cycles since acquisition began
   // fitted level comes straight from the bench
   assign gps_fitted = fitted;
   // a fix takes a few cycles to settle, like a real receiver
   always @(posedge clk_sys)
   begin
      if (!acquire)
      begin
         cnt <= 0;
         gps_fix_valid <= 1'b0;
         // no fix: time lines carry junk, never the last good value
         gps_time <= ~fix_time;
      end
      else if (cnt < FIX_DELAY)
      begin
         cnt <= cnt + 1;
      end
      else
      begin
         gps_fix_valid <= 1'b1;
         gps_time <= fix_time;
      end
   end
endmodule

// file: test/testbench.sv
`timescale 1ns/1ps
`include "tcc_regs.svh"
module testbench
   import tcc_pkg::*;
;
   logic clk_sys = 0, rst_n = 0; // clock and reset
   logic psel = 0, penable = 0, pwrite = 0; // apb request
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr;
   logic soft_reset = 0, power_ok = 1; // system state
   logic fitted = 0, acquire = 0; // gps model control
   tcc_time_t fix_time = '0;
   logic gps_fitted, gps_fix_valid, second_pulse, running;
   tcc_time_t gps_time;
   tcc_disp_t stamp_time;
   int num_errors = 0, tests_run = 0;
   logic [31:0] q, q2;
   logic e;
   int n;
   // short second keeps the run small
   tcc_top #(.SEC_CYCLES(100), .TRIM_STEP(2)) dut (.clk_sys(clk_sys),
      .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .soft_reset(soft_reset), .power_ok(power_ok),
      .gps_fitted(gps_fitted), .gps_fix_valid(gps_fix_valid),
      .gps_time(gps_time), .stamp_time(stamp_time),
      .second_pulse(second_pulse), .running(running));
   tcc_gps_model gps (.clk_sys(clk_sys), .fitted(fitted),
      .acquire(acquire), .fix_time(fix_time), .gps_fitted(gps_fitted),
      .gps_fix_valid(gps_fix_valid), .gps_time(gps_time));
   // 125 MHz clock
   always #4 clk_sys = ~clk_sys;
   // one apb transfer; waits on pready, the watchdog bounds it
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      int k;
      begin
         k = 0;
         @(posedge clk_sys);
         psel <= 1'b1;
         pwrite <= wr;
         paddr <= a;
         pwdata <= d;
         @(posedge clk_sys);
         penable <= 1'b1;
         do
         begin
            @(posedge clk_sys);
            k++;
         end
         while (pready !== 1'b1);
         q = prdata;
         e = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_disp(input tcc_disp_t got, input tcc_disp_t exp);
      tests_run++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: stamp %h expected %h", $time, got, exp);
      end
   endtask
   // cycles until next second pulse, bounded
   task automatic wait_pulse();
      n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (second_pulse !== 1'b1 && n < 400);
   endtask
   function automatic logic [31:0] dw(tcc_time_t t);
      return {3'h0, t.day, 4'h0, t.month, 2'h0, t.year};
   endfunction
   function automatic logic [31:0] tw(tcc_time_t t, logic [1:0] sh);
      return {sh, 9'h0, t.hour, 2'h0, t.minute, 2'h0, t.second};
   endfunction
   // load a typed entry: date word, time word, then control strobe
   task automatic enter(input tcc_time_t t, input logic secs);
      apb(1'b1, `TCC_OFS_SET_DATE, dw(t));
      apb(1'b1, `TCC_OFS_SET_TIME, tw(t, 2'h0));
      apb(1'b1, `TCC_OFS_CTRL, {29'h0, secs, 2'h1});
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // watchdog: all tests take well under 20000 cycles
   initial
   begin
      #400000;
      num_errors++;
      $display("mismatch at %0t: watchdog expired", $time);
      print_verdict();
   end
   tcc_time_t t1 = {14'h07d6, 4'hc, 5'h01, 5'h0e, 6'h1e, 6'h2d};
   tcc_time_t t2 = {14'h07d6, 4'hc, 5'h01, 5'h01, 6'h1e, 6'h00};
   tcc_time_t t3 = {14'h07d7, 4'h3, 5'h0a, 5'h05, 6'h06, 6'h07};
   tcc_time_t t0 = {14'h07d0, 4'h1, 5'h01, 5'h00, 6'h00, 6'h00};
   initial
   begin
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      // reset values and unmapped access
      apb(1'b0, `TCC_OFS_TRIM, 32'h0);
      chk_word(q, 32'h8);
      apb(1'b0, `TCC_OFS_ZONE, 32'h0);
      chk_word(q, 32'h0);
      apb(1'b0, `TCC_OFS_NOW_DATE, 32'h0);
      chk_word(q, dw(t0));
      apb(1'b0, 8'h2c, 32'h0);
      chk_word({31'h0, e}, 32'h1);
      chk_disp(stamp_time, {2'h0, t0});
      apb(1'b0, `TCC_OFS_PATTERN, 32'h0);
      chk_word(q, 32'h0);
      apb(1'b1, `TCC_OFS_PATTERN, 32'h0000005a);
      apb(1'b0, `TCC_OFS_PATTERN, 32'h0);
      chk_word(q, 32'h0000005a);
      $display("test reset done");
      // entry with seconds, then without
      enter(t1, 1'b1);
      apb(1'b0, `TCC_OFS_NOW_TIME, 32'h0);
      chk_word(q, tw(t1, 2'h0));
      apb(1'b0, `TCC_OFS_NOW_DATE, 32'h0);
      chk_word(q, dw(t1));
      chk_disp(stamp_time, {2'h0, t1});
      enter(t1, 1'b0);
      apb(1'b0, `TCC_OFS_NOW_TIME, 32'h0);
      chk_word(q, tw(t1, 2'h0) & 32'hffffffc0);
      $display("test entry done");
      // trim extremes change the second length by 2 cycles a step
      for (int i = 3; i >= 0; i--)
      begin
         apb(1'b1, `TCC_OFS_TRIM, {28'h0, 4'(i * 5)});
         wait_pulse();
         wait_pulse();
         chk_word(32'(n), 32'(100 + (i * 5 - 8) * 2));
      end
      $display("test trim done");
      // hour offset, range, display shift, report snapshot
      apb(1'b1, `TCC_OFS_ZONE, 32'hfffffffd);
      apb(1'b1, `TCC_OFS_ZONE, 32'h0000000d);
      apb(1'b0, `TCC_OFS_ZONE, 32'h0);
      chk_word(q, 32'hfffffffd);
      enter(t2, 1'b1);
      // stamp flop follows the load one edge later
      repeat (2) @(posedge clk_sys);
      // 01 h minus 3 wraps to 22 h of the previous day
      chk_disp(stamp_time, {2'h3, t2} + 42'h15 * 42'h1000);
      apb(1'b1, `TCC_OFS_CTRL, 32'h2);
      apb(1'b0, `TCC_OFS_STATUS, 32'h0);
      chk_word(q & 32'h4, 32'h4);
      apb(1'b0, `TCC_OFS_REP_TIME, 32'h0);
      chk_word(q, {2'h3, 9'h0, 5'h16, 2'h0, 6'h1e, 2'h0, 6'h00});
      apb(1'b0, `TCC_OFS_REP_DATE, 32'h0);
      chk_word(q, dw(t2));
      apb(1'b0, `TCC_OFS_STATUS, 32'h0);
      chk_word(q & 32'h4, 32'h0);
      apb(1'b1, `TCC_OFS_ZONE, 32'h0000000c);
      enter(t1, 1'b1);
      repeat (2) @(posedge clk_sys);
      chk_disp(stamp_time, {2'h1, t1} - 42'hc * 42'h1000);
      $display("test offset done");
      // soft reset stops, power cycle restarts
      soft_reset <= 1'b1;
      @(posedge clk_sys);
      soft_reset <= 1'b0;
      apb(1'b0, `TCC_OFS_NOW_TIME, 32'h0);
      q2 = q;
      repeat (250) @(posedge clk_sys);
      apb(1'b0, `TCC_OFS_NOW_TIME, 32'h0);
      chk_word(q, q2);
      chk_word({31'h0, running}, 32'h0);
      power_ok <= 1'b0;
      repeat (3) @(posedge clk_sys);
      power_ok <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk_word({31'h0, running}, 32'h1);
      // the calendar must count again after power-on
      apb(1'b0, `TCC_OFS_NOW_TIME, 32'h0);
      q2 = q;
      repeat (100) @(posedge clk_sys);
      apb(1'b0, `TCC_OFS_NOW_TIME, 32'h0);
      chk_word({31'h0, q != q2}, 32'h1);
      $display("test stop done");
      // gps: no load while unfitted, load once fitted
      fix_time <= t3;
      acquire <= 1'b1;
      repeat (20) @(posedge clk_sys);
      apb(1'b0, `TCC_OFS_NOW_DATE, 32'h0);
      chk_word(q, dw(t1));
      acquire <= 1'b0;
      fitted <= 1'b1;
      repeat (3) @(posedge clk_sys);
      acquire <= 1'b1;
      repeat (12) @(posedge clk_sys);
      apb(1'b0, `TCC_OFS_NOW_DATE, 32'h0);
      chk_word(q, dw(t3));
      apb(1'b0, `TCC_OFS_NOW_TIME, 32'h0);
      chk_word(q, tw(t3, 2'h0));
      apb(1'b0, `TCC_OFS_STATUS, 32'h0);
      chk_word(q & 32'ha, 32'ha);
      apb(1'b1, `TCC_OFS_STATUS, 32'h2);
      apb(1'b0, `TCC_OFS_STATUS, 32'h0);
      chk_word(q & 32'h2, 32'h0);
      $display("test gps done");
      print_verdict();
   end
endmodule
